// ===== fpc_cpu_model.sv
// Purpose: Processor model facing the front panel block
// Assumes: Three-clock machine cycles; signals change on the falling edge
// Notes: Bytes read while the panel drives the data bus are queued in rd_q
`timescale 1ns/1ns
`default_nettype none
module fpc_cpu_model (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic stop_req,
    input wire logic [7:0] jam_data,
    input wire logic jam_oe,
    output logic [15:0] bus_addr,
    output logic [7:0] cpu_data,
    output logic [7:0] bus_status,
    output logic cyc_sync,
    output logic cpu_dbin,
    output logic cpu_wr
);
    logic [7:0] rd_q[$];
    logic io_busy = 1'h0;
    int phase = 0;
    ////////////////////////////////////////////////////////////////////////
    // Fetch cycles start only while the panel releases the stop request
    always @(negedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_addr <= 16'h0000;
            cpu_data <= 8'h00;
            bus_status <= 8'h00;
            cyc_sync <= 1'h0;
            cpu_dbin <= 1'h0;
            cpu_wr <= 1'h0;
            phase <= 0;
        end else if (!io_busy) begin
            cyc_sync <= 1'h0;
            // Undriven bus shows a changing pattern, not a held value
            cpu_data <= (cpu_dbin && jam_oe) ? jam_data : ~cpu_data;
            if (phase == 0 && stop_req === 1'h0) begin
                cyc_sync <= 1'h1;
                cpu_dbin <= 1'h1;
                bus_status <= 8'he0;
                phase <= 1;
            end else if (phase == 1) begin
                phase <= 2;
            end else if (phase == 2) begin
                if (jam_oe === 1'h1) rd_q.push_back(jam_data);
                cpu_dbin <= 1'h0;
                bus_addr <= bus_addr + 16'h0001;
                phase <= 0;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // One port cycle, only called while stopped
    task automatic io_cycle(input logic inp, input logic [7:0] port, input logic [7:0] d);
        @(posedge core_clk);
        io_busy = 1'h1;
        @(negedge core_clk);
        bus_addr <= {port, port};
        bus_status <= inp ? 8'h10 : 8'h08;
        cpu_dbin <= inp;
        cpu_wr <= !inp;
        cpu_data <= d;
        repeat (3) @(negedge core_clk);
        if (inp) rd_q.push_back(jam_data);
        cpu_dbin <= 1'h0;
        cpu_wr <= 1'h0;
        bus_status <= 8'h00;
        @(posedge core_clk);
        io_busy = 1'h0;
    endtask : io_cycle
endmodule : fpc_cpu_model
`default_nettype wire

// ===== fpc_front_panel.sv
// Purpose: Front panel continuous functions, jam logic, port FF and lamps
// Assumes: Bus and switch inputs synchronous to core_clk
// Notes: stop_req high holds the processor in wait; cyc_sync marks each machine cycle start
`timescale 1ns/1ns
`default_nettype none

module fpc_front_panel
    import fpc_pkg::*;
#(
    parameter int REPEAT_CYCLES = REPEAT_CYCLES_NOM
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic continuous_nop_switch,
    input wire logic continuous_deposit_switch,
    input wire logic continuous_repeat_switch,
    input wire logic [7:0] opcode_switch_pack,
    input wire logic [7:0] low_switch_byte,
    input wire logic [7:0] high_switch_byte,
    input wire logic examine_up,
    input wire logic examine_next_down,
    input wire logic deposit_up,
    input wire logic deposit_next_down,
    input wire logic run_stop_toggle,
    input wire logic breakpoint_invert,
    input wire logic addr_data_stop_en,
    input wire logic breakpoint_reset,
    input wire logic [3:0] repeat_rate_trim,
    input wire logic [15:0] bus_addr,
    input wire logic [7:0] cpu_data,
    input wire logic [7:0] bus_status,
    input wire logic cyc_sync,
    input wire logic cpu_dbin,
    input wire logic cpu_wr,
    input wire logic cpu_wait_ack,
    input wire logic cpu_hold_ack,
    input wire logic option_signal,
    output logic stop_req,
    output logic [7:0] jam_data,
    output logic jam_oe,
    output logic panel_mwrite,
    output logic [15:0] address_lamps,
    output logic [7:0] data_lamps,
    output logic [7:0] status_lamps,
    output logic run_lamp,
    output logic wait_lamp,
    output logic hold_ack_lamp,
    output logic option_lamp,
    output logic nop_active_lamp,
    output logic deposit_active_lamp,
    output logic repeat_enabled_lamp,
    output logic latch_triggered_lamp,
    output logic [7:0] port_output_lamps
);
    localparam int TRIM_UNIT = REPEAT_CYCLES / TRIM_STEPS;

    fpc_state_t state;
    logic [1:0] step_len;
    logic [1:0] cyc_idx;
    logic dep_after;
    logic bp_latched;
    logic [19:0] tick_cnt;
    logic tick;
    logic exam_up_q;
    logic exam_dn_q;
    logic dep_up_q;
    logic dep_dn_q;
    logic run_mode;
    logic cn_on;
    logic cd_on;
    logic port_rd;
    logic port_wr;
    logic start_exam;
    logic start_nop;
    logic start_dep;
    logic start_dep_next;
    logic [7:0] next_jam_data;
    logic next_jam_oe;
    logic [31:0] reload;

    ////////////////////////////////////////////////////////////////////////
    // Mode decode
    assign run_mode = run_stop_toggle && !bp_latched;
    assign cn_on = continuous_nop_switch && !run_mode;
    assign cd_on = continuous_deposit_switch && !run_mode;
    assign port_rd = bus_status[ST_INP] && bus_addr[7:0] == IO_PORT_FF;
    assign port_wr = bus_status[ST_OUT] && bus_addr[7:0] == IO_PORT_FF;
    assign reload = 32'(REPEAT_CYCLES) + 32'(TRIM_UNIT) * 32'(repeat_rate_trim) - 32'(TRIM_UNIT) * 32'(TRIM_MID);

    always_comb begin
        start_exam = 1'b0;
        start_nop = 1'b0;
        start_dep = 1'b0;
        start_dep_next = 1'b0;
        if (!run_mode && state == FPC_IDLE) begin
            if (continuous_repeat_switch) begin
                start_exam = tick && examine_up;
                start_nop = tick && examine_next_down;
                start_dep_next = tick && deposit_next_down;
            end else begin
                start_exam = examine_up && !exam_up_q;
                start_nop = examine_next_down && !exam_dn_q;
                start_dep_next = deposit_next_down && !dep_dn_q;
            end
            start_dep = (deposit_up && !dep_up_q) || cd_on;
            start_nop = start_nop || cn_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Repeat timer with trim
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt <= 20'h00000;
            tick <= 1'b0;
        end else if (tick_cnt == 20'h00000) begin
            tick_cnt <= reload[19:0] - 20'h00001;
            tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt - 20'h00001;
            tick <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            exam_up_q <= 1'b0;
            exam_dn_q <= 1'b0;
            dep_up_q <= 1'b0;
            dep_dn_q <= 1'b0;
        end else begin
            exam_up_q <= examine_up;
            exam_dn_q <= examine_next_down;
            dep_up_q <= deposit_up;
            dep_dn_q <= deposit_next_down;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: release processor for a counted number of cycles
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= FPC_IDLE;
            step_len <= 2'h0;
            cyc_idx <= 2'h0;
            dep_after <= 1'b0;
        end else begin
            unique case (state)
                FPC_IDLE: begin
                    cyc_idx <= 2'h0;
                    if (start_exam) begin
                        state <= FPC_STEP;
                        step_len <= EXAM_CYCLES;
                        dep_after <= 1'b0;
                    end else if (start_nop || start_dep_next) begin
                        state <= FPC_STEP;
                        step_len <= NOP_CYCLES;
                        dep_after <= start_dep_next;
                    end else if (start_dep) begin
                        state <= FPC_DEPOSIT;
                    end
                end
                FPC_STEP: begin
                    if (cyc_sync) begin
                        if (cyc_idx + 2'h1 == step_len) begin
                            state <= dep_after ? FPC_DEPOSIT : FPC_IDLE;
                            cyc_idx <= 2'h0;
                        end else begin
                            cyc_idx <= cyc_idx + 2'h1;
                        end
                    end
                end
                FPC_DEPOSIT: begin
                    // Wait for the processor read to end before writing
                    if (!cpu_dbin) begin
                        state <= FPC_IDLE;
                        dep_after <= 1'b0;
                    end
                end
                default: state <= FPC_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data jam onto processor input bus
    always_comb begin
        next_jam_data = BYTE_RESET;
        next_jam_oe = 1'b0;
        if (port_rd && cpu_dbin) begin
            next_jam_data = high_switch_byte;
            next_jam_oe = 1'b1;
        end else if (state == FPC_STEP && cpu_dbin && (cyc_sync || !jam_oe)) begin
            next_jam_oe = 1'b1;
            if (step_len == NOP_CYCLES) begin
                next_jam_data = OP_NOP;
            end else begin
                unique case (cyc_idx)
                    2'h0: next_jam_data = opcode_switch_pack;
                    2'h1: next_jam_data = low_switch_byte;
                    default: next_jam_data = high_switch_byte;
                endcase
            end
        end else if (jam_oe && cpu_dbin) begin
            // Hold the byte for the whole read
            next_jam_data = jam_data;
            next_jam_oe = 1'b1;
        end else if (state == FPC_DEPOSIT && !cpu_dbin) begin
            next_jam_data = low_switch_byte;
            next_jam_oe = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            jam_data <= BYTE_RESET;
            jam_oe <= 1'b0;
            panel_mwrite <= 1'b0;
            stop_req <= 1'b1;
        end else begin
            jam_data <= next_jam_data;
            jam_oe <= next_jam_oe;
            panel_mwrite <= state == FPC_DEPOSIT && !cpu_dbin;
            stop_req <= !(run_mode || state == FPC_STEP);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port FF output latch and inverted data breakpoint
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            port_output_lamps <= BYTE_RESET;
        end else if (port_wr && cpu_wr) begin
            port_output_lamps <= cpu_data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bp_latched <= 1'b0;
        end else if (run_mode && breakpoint_invert && !addr_data_stop_en && bus_status[ST_MEMR] && cpu_dbin
                     && cpu_data != low_switch_byte) begin
            bp_latched <= 1'b1;
        end else if (breakpoint_reset) begin
            bp_latched <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lamps
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            address_lamps <= ADDR_RESET;
            data_lamps <= BYTE_RESET;
            status_lamps <= BYTE_RESET;
            run_lamp <= 1'b0;
            wait_lamp <= 1'b0;
            hold_ack_lamp <= 1'b0;
            option_lamp <= 1'b0;
            nop_active_lamp <= 1'b0;
            deposit_active_lamp <= 1'b0;
            repeat_enabled_lamp <= 1'b0;
            latch_triggered_lamp <= 1'b0;
        end else begin
            address_lamps <= bus_addr;
            data_lamps <= cpu_data;
            status_lamps <= bus_status;
            run_lamp <= run_mode;
            wait_lamp <= cpu_wait_ack;
            hold_ack_lamp <= cpu_hold_ack;
            option_lamp <= option_signal;
            nop_active_lamp <= cn_on;
            deposit_active_lamp <= cd_on;
            repeat_enabled_lamp <= continuous_repeat_switch;
            latch_triggered_lamp <= bp_latched;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_cn_lamp;
        @(posedge core_clk) disable iff (!rst_b)
        (continuous_nop_switch && !run_mode) |=> nop_active_lamp;
    endproperty
    a_cn_lamp: assert property (p_cn_lamp) else $error("nop lamp not lit");

    property p_cn_step;
        @(posedge core_clk) disable iff (!rst_b)
        (state == FPC_IDLE && continuous_nop_switch && !run_stop_toggle && !bp_latched) |=> state == FPC_STEP;
    endproperty
    a_cn_step: assert property (p_cn_step) else $error("continuous nop not launched");

    property p_dep_pulse;
        @(posedge core_clk) disable iff (!rst_b)
        state == FPC_DEPOSIT && !cpu_dbin |=> panel_mwrite && jam_oe && jam_data == $past(low_switch_byte)
            ##1 !panel_mwrite;
    endproperty
    a_dep_pulse: assert property (p_dep_pulse) else $error("deposit write wrong");

    property p_no_run_exam;
        @(posedge core_clk) disable iff (!rst_b)
        run_mode && state == FPC_IDLE |=> state != FPC_STEP || $past(state) != FPC_IDLE;
    endproperty
    a_no_run_exam: assert property (p_no_run_exam) else $error("step started in run");

    property p_port_in;
        @(posedge core_clk) disable iff (!rst_b)
        port_rd && cpu_dbin |=> jam_oe && jam_data == $past(high_switch_byte);
    endproperty
    a_port_in: assert property (p_port_in) else $error("port ff read wrong");

    property p_port_out;
        @(posedge core_clk) disable iff (!rst_b)
        port_wr && cpu_wr |=> port_output_lamps == $past(cpu_data);
    endproperty
    a_port_out: assert property (p_port_out) else $error("port ff latch wrong");

    property p_addr_lamps;
        @(posedge core_clk) disable iff (!rst_b)
        ##1 address_lamps == $past(bus_addr) && data_lamps == $past(cpu_data);
    endproperty
    a_addr_lamps: assert property (p_addr_lamps) else $error("address or data lamps stale");

    property p_exam_first;
        @(posedge core_clk) disable iff (!rst_b)
        state == FPC_STEP && step_len == EXAM_CYCLES && cyc_idx == 2'h0 && cpu_dbin && !port_rd
            |=> jam_data == $past(opcode_switch_pack);
    endproperty
    a_exam_first: assert property (p_exam_first) else $error("first examine byte wrong");

    property p_bp_stop;
        @(posedge core_clk) disable iff (!rst_b)
        run_mode && breakpoint_invert && !addr_data_stop_en && bus_status[ST_MEMR] && cpu_dbin
            && cpu_data != low_switch_byte |=> ##1 stop_req && latch_triggered_lamp;
    endproperty
    a_bp_stop: assert property (p_bp_stop) else $error("mismatch breakpoint missed");

endmodule : fpc_front_panel

`default_nettype wire

// ===== fpc_pkg.sv
// Purpose: Shared constants for the front panel continuous function block
// Assumes: 100 MHz core clock
// Notes: Opcode and port values are processor encodings
package fpc_pkg;
    localparam int CLK_MHZ = 100;
    localparam int REPEAT_TIME_US = 1000;
    localparam int REPEAT_CYCLES_NOM = REPEAT_TIME_US * CLK_MHZ;
    localparam int TRIM_STEPS = 16;
    localparam logic [3:0] TRIM_MID = 4'h8;
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] IO_PORT_FF = 8'hff;
    localparam logic [1:0] EXAM_CYCLES = 2'h3;
    localparam logic [1:0] NOP_CYCLES = 2'h1;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // Status lamp bit positions
    localparam int ST_HALTA = 0;
    localparam int ST_INTA = 1;
    localparam int ST_OPT = 2;
    localparam int ST_OUT = 3;
    localparam int ST_INP = 4;
    localparam int ST_WO = 5;
    localparam int ST_MEMR = 6;
    localparam int ST_M1 = 7;
    typedef enum logic [1:0] {
        FPC_IDLE = 2'b00,
        FPC_STEP = 2'b01,
        FPC_DEPOSIT = 2'b11
    } fpc_state_t;
endpackage : fpc_pkg

// ===== front_panel_continuous_functions_test.sv
// Purpose: Self-checking bench for the front panel block
// Assumes: Repeat period shortened to RC cycles, trim at nominal except one t_repeat pass at trim 0
// Notes: Inputs change on the falling edge
`timescale 1ns/1ns
`default_nettype none
module front_panel_continuous_functions_test;
    import fpc_pkg::*;
    localparam int RC = 64;
    logic core_clk = 1'h0, rst_b = 1'h0, continuous_nop_switch = 1'h0, continuous_deposit_switch = 1'h0;
    logic continuous_repeat_switch = 1'h0, examine_up = 1'h0, examine_next_down = 1'h0, deposit_up = 1'h0;
    logic deposit_next_down = 1'h0, run_stop_toggle = 1'h0, breakpoint_invert = 1'h0, addr_data_stop_en = 1'h0;
    logic breakpoint_reset = 1'h0, cpu_wait_ack = 1'h0, cpu_hold_ack = 1'h0, option_signal = 1'h0;
    logic [7:0] opcode_switch_pack = 8'hc3, low_switch_byte = 8'h00, high_switch_byte = 8'h00;
    logic [3:0] repeat_rate_trim = TRIM_MID;
    logic [15:0] bus_addr, address_lamps;
    logic [7:0] cpu_data, bus_status, jam_data, data_lamps, status_lamps, port_output_lamps;
    logic cyc_sync, cpu_dbin, cpu_wr, stop_req, jam_oe, panel_mwrite, run_lamp, wait_lamp, hold_ack_lamp;
    logic option_lamp, nop_active_lamp, deposit_active_lamp, repeat_enabled_lamp, latch_triggered_lamp;
    int err_count = 0;
    int samples_checked = 0;
    int n;
    logic [15:0] a;
    fpc_front_panel #(.REPEAT_CYCLES(RC)) uut (.core_clk, .rst_b, .continuous_nop_switch,
        .continuous_deposit_switch, .continuous_repeat_switch, .opcode_switch_pack, .low_switch_byte,
        .high_switch_byte, .examine_up, .examine_next_down, .deposit_up, .deposit_next_down, .run_stop_toggle,
        .breakpoint_invert, .addr_data_stop_en, .breakpoint_reset, .repeat_rate_trim, .bus_addr, .cpu_data,
        .bus_status, .cyc_sync, .cpu_dbin, .cpu_wr, .cpu_wait_ack, .cpu_hold_ack, .option_signal, .stop_req,
        .jam_data, .jam_oe, .panel_mwrite, .address_lamps, .data_lamps, .status_lamps, .run_lamp, .wait_lamp,
        .hold_ack_lamp, .option_lamp, .nop_active_lamp, .deposit_active_lamp, .repeat_enabled_lamp,
        .latch_triggered_lamp, .port_output_lamps);
    fpc_cpu_model u_cpu (.core_clk, .rst_b, .stop_req, .jam_data, .jam_oe, .bus_addr, .cpu_data, .bus_status,
        .cyc_sync, .cpu_dbin, .cpu_wr);
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic give_verdict;
        $display("errors=%0d checks=%0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    task automatic cycles(input int k);
        repeat (k) @(negedge core_clk);
    endtask : cycles
    task automatic wait_stop;
        int i;
        int s;
        i = 0;
        s = 0;
        // Stopped only when the stop request stays up, not for a one-cycle gap
        while (s < 4 && i < 400) begin
            @(negedge core_clk);
            s = (stop_req === 1'h1) ? s + 1 : 0;
            i++;
        end
        if (s < 4) begin
            check({15'h0000, stop_req}, 16'h0001);
            give_verdict();
        end
    endtask : wait_stop
    task automatic count_mw(input int k, output int cnt);
        cnt = 0;
        repeat (k) begin
            @(negedge core_clk);
            if (panel_mwrite === 1'h1) begin
                cnt++;
                check({8'h00, jam_data}, {8'h00, low_switch_byte});
            end
        end
    endtask : count_mw
    ////////////////////////////////////////////////////////////////////////
    task automatic t_lamps;
        logic [7:0] d;
        cpu_wait_ack = 1'h1;
        cpu_hold_ack = 1'h1;
        option_signal = 1'h1;
        @(posedge core_clk);
        d = cpu_data;
        @(negedge core_clk);
        check(address_lamps, bus_addr);
        check({8'h00, status_lamps}, {8'h00, bus_status});
        check({8'h00, data_lamps}, {8'h00, d});
        check({13'h0000, wait_lamp, hold_ack_lamp, option_lamp}, 16'h0007);
    endtask : t_lamps
    task automatic t_deposit;
        low_switch_byte = 8'h5a;
        deposit_up = 1'h1;
        count_mw(30, n);
        check(16'(n), 16'h0001);
        check({15'h0000, stop_req}, 16'h0001);
        deposit_up = 1'h0;
        continuous_deposit_switch = 1'h1;
        cycles(2);
        check({15'h0000, deposit_active_lamp}, 16'h0001);
        count_mw(40, n);
        check(16'(n >= 2), 16'h0001);
        check({15'h0000, stop_req}, 16'h0001);
        continuous_deposit_switch = 1'h0;
        cycles(4);
    endtask : t_deposit
    task automatic t_nop;
        a = bus_addr;
        u_cpu.rd_q.delete();
        continuous_nop_switch = 1'h1;
        cycles(2);
        check({15'h0000, nop_active_lamp}, 16'h0001);
        cycles(60);
        check(16'(bus_addr - a > 16'h0004), 16'h0001);
        check({8'h00, u_cpu.rd_q[0]}, {8'h00, OP_NOP});
        check(16'(u_cpu.rd_q.size() > 4), 16'h0001);
        continuous_nop_switch = 1'h0;
        wait_stop();
    endtask : t_nop
    task automatic t_examine;
        opcode_switch_pack = 8'hdb;
        low_switch_byte = 8'h3c;
        high_switch_byte = 8'ha5;
        u_cpu.rd_q.delete();
        examine_up = 1'h1;
        cycles(3);
        examine_up = 1'h0;
        wait_stop();
        cycles(4);
        check(16'(u_cpu.rd_q.size()), 16'h0003);
        check({8'h00, u_cpu.rd_q[0]}, 16'h00db);
        check({u_cpu.rd_q[1], u_cpu.rd_q[2]}, 16'h3ca5);
    endtask : t_examine
    task automatic t_repeat;
        continuous_repeat_switch = 1'h1;
        cycles(2);
        check({15'h0000, repeat_enabled_lamp}, 16'h0001);
        u_cpu.rd_q.delete();
        examine_up = 1'h1;
        cycles(4 * RC);
        examine_up = 1'h0;
        wait_stop();
        n = u_cpu.rd_q.size();
        check(16'(n >= 9 && n <= 15), 16'h0001);
        check({8'h00, u_cpu.rd_q[3]}, 16'h00db);
        a = bus_addr;
        examine_next_down = 1'h1;
        cycles(4 * RC);
        examine_next_down = 1'h0;
        wait_stop();
        check(16'(bus_addr - a >= 16'h0003 && bus_addr - a <= 16'h0005), 16'h0001);
        deposit_next_down = 1'h1;
        count_mw(4 * RC, n);
        deposit_next_down = 1'h0;
        check(16'(n >= 3 && n <= 5), 16'h0001);
        wait_stop();
        repeat_rate_trim = 4'h0;
        cycles(RC);
        a = bus_addr;
        examine_next_down = 1'h1;
        cycles(4 * RC);
        examine_next_down = 1'h0;
        wait_stop();
        repeat_rate_trim = TRIM_MID;
        check(16'(bus_addr - a >= 16'h0007 && bus_addr - a <= 16'h0009), 16'h0001);
        continuous_repeat_switch = 1'h0;
    endtask : t_repeat
    task automatic t_port;
        high_switch_byte = 8'h77;
        u_cpu.rd_q.delete();
        u_cpu.io_cycle(1'h1, 8'hff, 8'h00);
        check({8'h00, u_cpu.rd_q[0]}, 16'h0077);
        check(address_lamps, 16'hffff);
        u_cpu.io_cycle(1'h0, 8'hff, 8'hc6);
        cycles(2);
        check({8'h00, port_output_lamps}, 16'h00c6);
        u_cpu.io_cycle(1'h0, 8'hfe, 8'h39);
        cycles(2);
        check({8'h00, port_output_lamps}, 16'h00c6);
    endtask : t_port
    task automatic t_run_mode;
        u_cpu.rd_q.delete();
        run_stop_toggle = 1'h1;
        cycles(4);
        check({15'h0000, run_lamp}, 16'h0001);
        examine_up = 1'h1;
        cycles(20);
        check(16'(u_cpu.rd_q.size()), 16'h0000);
        examine_up = 1'h0;
        run_stop_toggle = 1'h0;
        wait_stop();
    endtask : t_run_mode
    task automatic t_breakpoint;
        breakpoint_invert = 1'h1;
        addr_data_stop_en = 1'h1;
        run_stop_toggle = 1'h1;
        cycles(10);
        check({15'h0000, latch_triggered_lamp}, 16'h0000);
        addr_data_stop_en = 1'h0;
        n = 0;
        while (latch_triggered_lamp !== 1'h1 && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        check({15'h0000, latch_triggered_lamp}, 16'h0001);
        if (n >= 100) give_verdict();
        cycles(2);
        check({14'h0000, stop_req, run_lamp}, 16'h0002);
        run_stop_toggle = 1'h0;
        breakpoint_invert = 1'h0;
        breakpoint_reset = 1'h1;
        cycles(2);
        breakpoint_reset = 1'h0;
        wait_stop();
        check({15'h0000, latch_triggered_lamp}, 16'h0000);
    endtask : t_breakpoint
    ////////////////////////////////////////////////////////////////////////
    initial begin
        cycles(4);
        check({15'h0000, stop_req}, 16'h0001);
        check({8'h00, port_output_lamps}, 16'h0000);
        rst_b = 1'h1;
        cycles(2);
        t_lamps();
        t_deposit();
        t_nop();
        t_examine();
        t_repeat();
        t_port();
        t_run_mode();
        t_breakpoint();
        give_verdict();
    end
endmodule : front_panel_continuous_functions_test
`default_nettype wire
